// ===== hw/tsd_pkg.sv
/*
 * Package for the tile status and debug register bank: register numbers,
 * field positions, reset values and the carrier structs.
 * Assumes a single core clock domain with the processor-status port on it.
 */
package tsd_pkg;

    localparam logic [7:0] TSD_REG_BOOT    = 8'h03;
    localparam logic [7:0] TSD_REG_SEC     = 8'h05;
    localparam logic [7:0] TSD_REG_RO_CTRL = 8'h06;
    localparam logic [7:0] TSD_REG_RO_TC   = 8'h07;
    localparam logic [7:0] TSD_REG_RO_TW   = 8'h08;
    localparam logic [7:0] TSD_REG_RO_PC   = 8'h09;
    localparam logic [7:0] TSD_REG_RO_PW   = 8'h0a;
    localparam logic [7:0] TSD_REG_RAMSZ   = 8'h0c;
    localparam logic [7:0] TSD_REG_DSTAT   = 8'h10;
    localparam logic [7:0] TSD_REG_DPC     = 8'h11;
    localparam logic [7:0] TSD_REG_DSP     = 8'h12;
    localparam logic [7:0] TSD_REG_DTHR    = 8'h13;
    localparam logic [7:0] TSD_REG_DRNUM   = 8'h14;

    // Boot status field positions
    localparam int TSD_BOOT_TILE_LSB = 16;
    localparam int TSD_BOOT_OVR_BIT  = 8;
    localparam int TSD_BOOT_C1OFF    = 5;
    localparam int TSD_BOOT_NOPOLL   = 4;
    localparam int TSD_BOOT_RAM      = 3;
    localparam int TSD_BOOT_JTAG     = 2;

    // Security word fields
    localparam int TSD_SEC_WLOCK     = 31;
    localparam int TSD_SEC_GDBG_DIS  = 14;
    localparam int TSD_SEC_LOCK_ALL  = 12;
    localparam int TSD_SEC_LOCK_LSB  = 8;
    localparam int TSD_SEC_REDUND    = 7;
    localparam int TSD_SEC_BOOT_OVR  = 5;
    localparam int TSD_SEC_JCFG_DIS  = 4;
    localparam int TSD_SEC_TAP_DIS   = 0;
    localparam logic [31:0] TSD_SEC_MASK = 32'h80005fb1;

    localparam int TSD_ROC_CORE_EN   = 1;
    localparam int TSD_ROC_PERI_EN   = 0;

    localparam logic [31:0] TSD_DSTAT_MASK  = 32'h000007df;
    localparam logic [31:0] TSD_DSTAT_WMASK = 32'h000006df;
    localparam int TSD_DSTAT_DI_BIT  = 8;
    localparam logic [31:0] TSD_DTHR_MASK   = 32'h000000ff;
    localparam logic [31:0] TSD_DRNUM_MASK  = 32'h0000001f;
    localparam logic [31:0] TSD_RAMSZ_MASK  = 32'hfffffffc;

    localparam logic [31:0] TSD_RST_WORD    = 32'h00000000;
    localparam logic [1:0]  TSD_RST_ROC     = 2'h0;

    // Oscillator must be stopped this long before its count is read
    localparam int TSD_RO_SETTLE_CYC = 10;

    typedef struct packed {
        logic [7:0] tile_num;
        logic       boot_ovr;
        logic       second_core_off;
        logic       no_otp_poll;
        logic       boot_ram;
        logic       boot_jtag;
        logic [1:0] pll_mode;
    } tsd_boot_t;

    typedef struct packed {
        logic [31:0] saved_status_word;
        logic [31:0] saved_program_counter;
        logic [31:0] saved_stack_pointer;
    } tsd_dbg_cap_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  num;
        logic [31:0] wdata;
    } tsd_ps_req_t;

endpackage

// ===== hw/tsd_regs.sv
/*
 * Tile status and debug register bank, reached through processor-status
 * reads and writes. Ring oscillator counters are modelled as counters on
 * external oscillator clocks, brought over by two-flop capture of a frozen
 * count. Assumes ps_req comes from logic on clk_sys.
 */
// Summary of operation
// - Boot word bits 23:16 give tile number, read-only.
// - Boot bit 3 RAM boot, bit 2 JTAG boot.
// - Boot bits 1:0 give sampled PLL mode pins.
// - Boot bits 5,4,8: core off, no poll, override.
// - Security register holds word loaded from OTP.
// - Security bit 31 blocks later security writes.
// - Bit 14 blocks global debug, bit 0 TAP.
// - Bit 4 blocks JTAG boot/PLL config access.
// - Bit 12 locks all sectors, 11:8 each.
// - Bit 7 enables redundancy, bit 5 OTP boot.
// - Four oscillators, two enables, reset zero.
// - Oscillators run asynchronous to tile clock.
// - Registers 0x07-0x0A return counts in 15:0.
// - Counts survive system reset.
// - Register 0x0C gives RAM size, bits 31:2.
// - Debug entry captures status, bits 10,9,8.
// - Status bits 7,6,4..0 keep thread flags.
// - Debug entry captures full program counter.
// - Debug entry captures stack pointer at 0x12.
// - Fetch operand one holds thread number 7:0.
// - Fetch operand two holds register 4:0.
// - Every register reached by status read/write.
`timescale 1ns/10ps
`default_nettype none

module tsd_regs
    import tsd_pkg::*;
#(
    parameter logic [31:0] RAM_BYTES = 32'h00080000
) (
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire tsd_ps_req_t  ps_req,
    output logic [31:0]       ps_rdata,
    output logic              ps_rvalid,
    input  wire tsd_boot_t    boot_in,
    input  wire logic         otp_load,
    input  wire logic [31:0]  otp_sec_word,
    input  wire logic         debug_mode,
    input  wire logic         debug_entry,
    input  wire tsd_dbg_cap_t dbg_cap,
    input  wire logic         osc_tile_cell,
    input  wire logic         osc_tile_wire,
    input  wire logic         osc_peri_cell,
    input  wire logic         osc_peri_wire,
    output logic [31:0]       sec_cfg,
    output logic              osc_core_en,
    output logic              osc_peri_en,
    output logic [7:0]        fetch_thread,
    output logic [4:0]        fetch_regnum
);

    logic [31:0] sec_ff,   nxt_sec;
    logic [1:0]  roc_ff,   nxt_roc;
    logic [31:0] dstat_ff, nxt_dstat;
    logic [31:0] dpc_ff,   nxt_dpc;
    logic [31:0] dsp_ff,   nxt_dsp;
    logic [7:0]  dthr_ff,  nxt_dthr;
    logic [4:0]  drnum_ff, nxt_drnum;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        rvalid_ff;
    tsd_boot_t   boot_s1_ff, boot_ff;
    logic [3:0]  osc_clk;
    logic [3:0]  osc_en;
    logic [15:0] cnt_sync1_ff [4];
    logic [15:0] cnt_sync2_ff [4];

    function automatic logic hit(input tsd_ps_req_t r, input logic [7:0] n);
        return r.wr && (r.num == n);
    endfunction

    // Pin straps double-flopped before use
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            boot_s1_ff <= '0;
            boot_ff    <= '0;
        end else begin
            boot_s1_ff <= boot_in;
            boot_ff    <= boot_s1_ff;
        end
    end

    always_comb begin
        nxt_sec   = sec_ff;
        nxt_roc   = roc_ff;
        nxt_dstat = dstat_ff;
        nxt_dpc   = dpc_ff;
        nxt_dsp   = dsp_ff;
        nxt_dthr  = dthr_ff;
        nxt_drnum = drnum_ff;
        if (otp_load) begin
            nxt_sec = otp_sec_word & TSD_SEC_MASK;
        end else if (hit(ps_req, TSD_REG_SEC) && !sec_ff[TSD_SEC_WLOCK]) begin
            nxt_sec = ps_req.wdata & TSD_SEC_MASK;
        end
        if (hit(ps_req, TSD_REG_RO_CTRL)) begin
            nxt_roc = ps_req.wdata[1:0];
        end
        if (debug_entry) begin
            // Snapshot on debugger entry
            nxt_dstat = dbg_cap.saved_status_word & TSD_DSTAT_MASK;
            nxt_dpc   = dbg_cap.saved_program_counter;
            nxt_dsp   = dbg_cap.saved_stack_pointer;
        end else if (debug_mode) begin
            if (hit(ps_req, TSD_REG_DSTAT)) begin
                // Current issue bit stays read-only
                nxt_dstat = (ps_req.wdata & TSD_DSTAT_WMASK)
                          | (dstat_ff & ~TSD_DSTAT_WMASK & TSD_DSTAT_MASK);
            end
            if (hit(ps_req, TSD_REG_DPC)) begin
                nxt_dpc = ps_req.wdata;
            end
            if (hit(ps_req, TSD_REG_DSP)) begin
                nxt_dsp = ps_req.wdata;
            end
        end
        if (debug_mode && hit(ps_req, TSD_REG_DTHR)) begin
            nxt_dthr = ps_req.wdata[7:0];
        end
        if (debug_mode && hit(ps_req, TSD_REG_DRNUM)) begin
            nxt_drnum = ps_req.wdata[4:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sec_ff   <= TSD_RST_WORD;
            roc_ff   <= TSD_RST_ROC;
            dstat_ff <= TSD_RST_WORD;
            dpc_ff   <= TSD_RST_WORD;
            dsp_ff   <= TSD_RST_WORD;
            dthr_ff  <= '0;
            drnum_ff <= '0;
        end else begin
            sec_ff   <= nxt_sec;
            roc_ff   <= nxt_roc;
            dstat_ff <= nxt_dstat;
            dpc_ff   <= nxt_dpc;
            dsp_ff   <= nxt_dsp;
            dthr_ff  <= nxt_dthr;
            drnum_ff <= nxt_drnum;
        end
    end

    // Oscillator counters: own clocks, no reset
    assign osc_clk = {osc_peri_wire, osc_peri_cell, osc_tile_wire, osc_tile_cell};
    assign osc_en  = {roc_ff[TSD_ROC_PERI_EN], roc_ff[TSD_ROC_PERI_EN],
                      roc_ff[TSD_ROC_CORE_EN], roc_ff[TSD_ROC_CORE_EN]};

    for (genvar g = 0; g < 4; g++) begin : g_osc
        logic [15:0] cnt_ff;
        logic        en_s1_ff, en_s2_ff, en_s3_ff;
        // Restart from zero on each start; with no reset, a count is unknown until the first start
        always_ff @(posedge osc_clk[g]) begin
            en_s1_ff <= osc_en[g];
            en_s2_ff <= en_s1_ff;
            en_s3_ff <= en_s2_ff;
            if (en_s2_ff && !en_s3_ff) begin
                cnt_ff <= 16'h0000;
            end else if (en_s2_ff) begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
        // Count is static once stopped; software waits before reading
        always_ff @(posedge clk_sys) begin
            cnt_sync1_ff[g] <= cnt_ff;
            cnt_sync2_ff[g] <= cnt_sync1_ff[g];
        end
    end

    // Core-clock view of how long each oscillator pair has been stopped
    localparam logic [3:0] SETTLE = 4'(TSD_RO_SETTLE_CYC);

    logic [1:0] osc_ran_ff,   nxt_osc_ran;
    logic [3:0] core_idle_ff, nxt_core_idle;
    logic [3:0] peri_idle_ff, nxt_peri_idle;

    function automatic logic [3:0] idle_step(input logic en, input logic [3:0] c);
        if (en) begin
            return 4'h0;
        end
        return (c == SETTLE) ? c : c + 4'h1;
    endfunction

    always_comb begin
        nxt_osc_ran   = osc_ran_ff | roc_ff;
        nxt_core_idle = idle_step(roc_ff[TSD_ROC_CORE_EN], core_idle_ff);
        nxt_peri_idle = idle_step(roc_ff[TSD_ROC_PERI_EN], peri_idle_ff);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            osc_ran_ff   <= 2'h0;
            core_idle_ff <= 4'h0;
            peri_idle_ff <= 4'h0;
        end else begin
            osc_ran_ff   <= nxt_osc_ran;
            core_idle_ff <= nxt_core_idle;
            peri_idle_ff <= nxt_peri_idle;
        end
    end

    always_comb begin
        nxt_rdata = '0;
        case (ps_req.num)
            TSD_REG_BOOT: begin
                nxt_rdata[TSD_BOOT_TILE_LSB +: 8] = boot_ff.tile_num;
                nxt_rdata[TSD_BOOT_OVR_BIT]       = boot_ff.boot_ovr;
                nxt_rdata[TSD_BOOT_C1OFF]         = boot_ff.second_core_off;
                nxt_rdata[TSD_BOOT_NOPOLL]        = boot_ff.no_otp_poll;
                nxt_rdata[TSD_BOOT_RAM]           = boot_ff.boot_ram;
                nxt_rdata[TSD_BOOT_JTAG]          = boot_ff.boot_jtag;
                nxt_rdata[1:0]                    = boot_ff.pll_mode;
            end
            TSD_REG_SEC:     nxt_rdata = sec_ff;
            TSD_REG_RO_CTRL: nxt_rdata[1:0] = roc_ff;
            TSD_REG_RO_TC:   nxt_rdata[15:0] = cnt_sync2_ff[0];
            TSD_REG_RO_TW:   nxt_rdata[15:0] = cnt_sync2_ff[1];
            TSD_REG_RO_PC:   nxt_rdata[15:0] = cnt_sync2_ff[2];
            TSD_REG_RO_PW:   nxt_rdata[15:0] = cnt_sync2_ff[3];
            TSD_REG_RAMSZ:   nxt_rdata = RAM_BYTES & TSD_RAMSZ_MASK;
            TSD_REG_DSTAT:   nxt_rdata = dstat_ff;
            TSD_REG_DPC:     nxt_rdata = dpc_ff;
            TSD_REG_DSP:     nxt_rdata = dsp_ff;
            TSD_REG_DTHR:    nxt_rdata[7:0] = dthr_ff;
            TSD_REG_DRNUM:   nxt_rdata[4:0] = drnum_ff;
            default:         nxt_rdata = '0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata_ff  <= '0;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= ps_req.rd;
            if (ps_req.rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign ps_rdata     = rdata_ff;
    assign ps_rvalid    = rvalid_ff;
    assign sec_cfg      = sec_ff;
    assign osc_core_en  = roc_ff[TSD_ROC_CORE_EN];
    assign osc_peri_en  = roc_ff[TSD_ROC_PERI_EN];
    assign fetch_thread = dthr_ff;
    assign fetch_regnum = drnum_ff;

    AST_CORE_FROZEN: assert property (@(posedge clk_sys) disable iff (!nrst)
        osc_ran_ff[TSD_ROC_CORE_EN] && core_idle_ff == SETTLE
            |=> $stable(cnt_sync2_ff[0]) && $stable(cnt_sync2_ff[1]))
        else $error("tile oscillator count moved while stopped");

    AST_PERI_FROZEN: assert property (@(posedge clk_sys) disable iff (!nrst)
        osc_ran_ff[TSD_ROC_PERI_EN] && peri_idle_ff == SETTLE
            |=> $stable(cnt_sync2_ff[2]) && $stable(cnt_sync2_ff[3]))
        else $error("peripheral oscillator count moved while stopped");

    AST_CNT_RSVD: assert property (@(posedge clk_sys) disable iff (!nrst)
        ps_req.rd && ps_req.num >= TSD_REG_RO_TC && ps_req.num <= TSD_REG_RO_PW
            |=> ps_rdata[31:16] == 16'h0000)
        else $error("oscillator count upper bits set");

    AST_SEC_OTP: assert property (@(posedge clk_sys) disable iff (!nrst)
        otp_load |=> sec_ff == ($past(otp_sec_word) & TSD_SEC_MASK))
        else $error("security word not loaded");

    AST_SEC_WR: assert property (@(posedge clk_sys) disable iff (!nrst)
        hit(ps_req, TSD_REG_SEC) && !sec_ff[TSD_SEC_WLOCK] && !otp_load
            |=> sec_ff == ($past(ps_req.wdata) & TSD_SEC_MASK))
        else $error("security word not written");

    AST_SEC_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
        !hit(ps_req, TSD_REG_SEC) && !otp_load |=> $stable(sec_ff))
        else $error("security word changed unasked");

    AST_ROC_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
        !hit(ps_req, TSD_REG_RO_CTRL) |=> $stable(roc_ff))
        else $error("oscillator control changed unasked");

    AST_ROC_RSVD: assert property (@(posedge clk_sys) disable iff (!nrst)
        ps_req.rd && ps_req.num == TSD_REG_RO_CTRL |=> ps_rdata[31:2] == 30'h0)
        else $error("oscillator control reserved bits set");

    AST_UNMAPPED: assert property (@(posedge clk_sys) disable iff (!nrst)
        ps_req.rd && ps_req.num == 8'h04 |=> ps_rdata == 32'h0)
        else $error("unmapped number read nonzero");

    AST_DSTAT_CAP: assert property (@(posedge clk_sys) disable iff (!nrst)
        debug_entry |=> dstat_ff == ($past(dbg_cap.saved_status_word) & TSD_DSTAT_MASK))
        else $error("status word not captured");

    AST_DSTAT_WR: assert property (@(posedge clk_sys) disable iff (!nrst)
        debug_mode && !debug_entry && hit(ps_req, TSD_REG_DSTAT)
            |=> (dstat_ff & TSD_DSTAT_WMASK) == ($past(ps_req.wdata) & TSD_DSTAT_WMASK))
        else $error("status word not written");

    AST_DPC_WR: assert property (@(posedge clk_sys) disable iff (!nrst)
        debug_mode && !debug_entry && hit(ps_req, TSD_REG_DPC)
            |=> dpc_ff == $past(ps_req.wdata))
        else $error("program counter not written");

    AST_DSP_WR: assert property (@(posedge clk_sys) disable iff (!nrst)
        debug_mode && !debug_entry && hit(ps_req, TSD_REG_DSP)
            |=> dsp_ff == $past(ps_req.wdata))
        else $error("stack pointer not written");

    AST_DTHR_WR: assert property (@(posedge clk_sys) disable iff (!nrst)
        debug_mode && hit(ps_req, TSD_REG_DTHR) |=> dthr_ff == $past(ps_req.wdata[7:0]))
        else $error("fetch thread not written");

    AST_DRNUM_WR: assert property (@(posedge clk_sys) disable iff (!nrst)
        debug_mode && hit(ps_req, TSD_REG_DRNUM) |=> drnum_ff == $past(ps_req.wdata[4:0]))
        else $error("fetch register number not written");

    AST_NODBG_REST: assert property (@(posedge clk_sys) disable iff (!nrst)
        !debug_mode && !debug_entry
            |=> $stable(dsp_ff) && $stable(dstat_ff) && $stable(drnum_ff))
        else $error("debug field written outside debug mode");

    AST_RVALID: assert property (@(posedge clk_sys) disable iff (!nrst)
        ps_req.rd |=> ps_rvalid)
        else $error("read not answered");

    AST_RVALID_LOW: assert property (@(posedge clk_sys) disable iff (!nrst)
        !ps_req.rd |=> !ps_rvalid)
        else $error("read answered without request");

    AST_RDATA_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
        !ps_req.rd |=> $stable(ps_rdata))
        else $error("read data changed without read");

    AST_BOOT_FIELDS: assert property (@(posedge clk_sys) disable iff (!nrst)
        ps_req.rd && ps_req.num == TSD_REG_BOOT
            |=> ps_rdata[3:0] == $past({boot_ff.boot_ram, boot_ff.boot_jtag, boot_ff.pll_mode}))
        else $error("boot source bits wrong");

    AST_BOOT_RSVD: assert property (@(posedge clk_sys) disable iff (!nrst)
        ps_req.rd && ps_req.num == TSD_REG_BOOT
            |=> ps_rdata[15:9] == 7'h00 && ps_rdata[7:6] == 2'h0
                && ps_rdata[8] == $past(boot_ff.boot_ovr))
        else $error("boot word upper fields wrong");

    AST_SEC_LOCK: assert property (@(posedge clk_sys) disable iff (!nrst)
        sec_ff[TSD_SEC_WLOCK] && !otp_load |=> $stable(sec_ff))
        else $error("security word changed while locked");
    AST_ROC_WR: assert property (@(posedge clk_sys) disable iff (!nrst)
        hit(ps_req, TSD_REG_RO_CTRL) |=> roc_ff == $past(ps_req.wdata[1:0]))
        else $error("oscillator control not written");
    AST_DBG_CAP: assert property (@(posedge clk_sys) disable iff (!nrst)
        debug_entry |=> dpc_ff == $past(dbg_cap.saved_program_counter))
        else $error("program counter not captured");
    AST_DSP_CAP: assert property (@(posedge clk_sys) disable iff (!nrst)
        debug_entry |=> dsp_ff == $past(dbg_cap.saved_stack_pointer))
        else $error("stack pointer not captured");
    AST_NODBG_WR: assert property (@(posedge clk_sys) disable iff (!nrst)
        !debug_mode && !debug_entry |=> $stable(dpc_ff) && $stable(dthr_ff))
        else $error("debug field written outside debug mode");
    AST_RSVD_ZERO: assert property (@(posedge clk_sys) disable iff (!nrst)
        (sec_ff & ~TSD_SEC_MASK) == '0 && (dstat_ff & ~TSD_DSTAT_MASK) == '0)
        else $error("reserved bit set");
    AST_READ_LAT: assert property (@(posedge clk_sys) disable iff (!nrst)
        ps_req.rd && ps_req.num == TSD_REG_RAMSZ
            |=> ps_rvalid && ps_rdata == (RAM_BYTES & TSD_RAMSZ_MASK))
        else $error("RAM size read wrong");
    AST_BOOT_RO: assert property (@(posedge clk_sys) disable iff (!nrst)
        ps_req.rd && ps_req.num == TSD_REG_BOOT
            |=> ps_rdata[TSD_BOOT_TILE_LSB +: 8] == $past(boot_ff.tile_num)
                && ps_rdata[31:24] == 8'h00)
        else $error("boot word tile number wrong");
    AST_DI_RO: assert property (@(posedge clk_sys) disable iff (!nrst)
        !debug_entry |=> $stable(dstat_ff[TSD_DSTAT_DI_BIT]))
        else $error("current issue bit written");

endmodule

`default_nettype wire

// ===== tb/testbench.sv
/*
 * Self-checking bench for tsd_regs: an array model of the bank is
 * compared with every read except the oscillator counts. Assumes tsd_pkg is compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import tsd_pkg::*;

    localparam logic [31:0] RAM_SZ = 32'h00040000;

    logic         clk_sys = 1'b0;
    logic         nrst = 1'b0;
    tsd_ps_req_t  ps_req = '0;
    logic [31:0]  ps_rdata;
    logic         ps_rvalid;
    tsd_boot_t    boot_in = '0;
    logic         otp_load = 1'b0;
    logic [31:0]  otp_sec_word = '0;
    logic         debug_mode = 1'b0;
    logic         debug_entry = 1'b0;
    tsd_dbg_cap_t dbg_cap = '0;
    logic [3:0]   osc = '0;
    logic [31:0]  sec_cfg;
    logic         osc_core_en;
    logic         osc_peri_en;
    logic [7:0]   fetch_thread;
    logic [4:0]   fetch_regnum;
    logic [31:0]  mdl [0:31];
    logic [31:0]  rv;
    logic [31:0]  cnt [0:3];
    int           err_total = 0;
    int           samples_checked = 0;

    always #5 clk_sys = ~clk_sys;
    // Oscillators unrelated to the core clock
    always #1.3 osc[0] = ~osc[0];
    always #1.7 osc[1] = ~osc[1];
    always #2.3 osc[2] = ~osc[2];
    always #2.9 osc[3] = ~osc[3];

    tsd_regs #(.RAM_BYTES(RAM_SZ)) dut (
        .clk_sys(clk_sys), .nrst(nrst), .ps_req(ps_req), .ps_rdata(ps_rdata),
        .ps_rvalid(ps_rvalid), .boot_in(boot_in), .otp_load(otp_load),
        .otp_sec_word(otp_sec_word), .debug_mode(debug_mode),
        .debug_entry(debug_entry), .dbg_cap(dbg_cap), .osc_tile_cell(osc[0]),
        .osc_tile_wire(osc[1]), .osc_peri_cell(osc[2]), .osc_peri_wire(osc[3]),
        .sec_cfg(sec_cfg), .osc_core_en(osc_core_en), .osc_peri_en(osc_peri_en),
        .fetch_thread(fetch_thread), .fetch_regnum(fetch_regnum)
    );

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic rd(input logic [7:0] n, output logic [31:0] d);
        @(posedge clk_sys);
        ps_req <= {1'b0, 1'b1, n, 32'h0};
        @(posedge clk_sys);
        ps_req.rd <= 1'b0;
        #1;
        chk("read valid", 32'h1, {31'h0, ps_rvalid});
        d = ps_rdata;
    endtask

    task automatic rdchk(input logic [7:0] n);
        rd(n, rv);
        chk($sformatf("reg %h", n), mdl[n], rv);
    endtask

    task automatic wr(input logic [7:0] n, input logic [31:0] d);
        @(posedge clk_sys);
        ps_req <= {1'b1, 1'b0, n, d};
        @(posedge clk_sys);
        ps_req.wr <= 1'b0;
        #1;
        case (n)
            TSD_REG_SEC: if (!mdl[n][TSD_SEC_WLOCK]) mdl[n] = d & TSD_SEC_MASK;
            TSD_REG_RO_CTRL: mdl[n] = d & 32'h3;
            TSD_REG_DSTAT: if (debug_mode) mdl[n] = (d & TSD_DSTAT_WMASK) | (mdl[n] & 32'h100);
            TSD_REG_DPC, TSD_REG_DSP: if (debug_mode) mdl[n] = d;
            TSD_REG_DTHR: if (debug_mode) mdl[n] = d & TSD_DTHR_MASK;
            TSD_REG_DRNUM: if (debug_mode) mdl[n] = d & TSD_DRNUM_MASK;
            default: ;
        endcase
    endtask

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(32'h29bf603f));
        foreach (mdl[i]) mdl[i] = 32'h0;
        mdl[TSD_REG_RAMSZ] = RAM_SZ & TSD_RAMSZ_MASK;
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (2) begin
            @(posedge clk_sys);
            boot_in <= tsd_boot_t'(15'($urandom));
            repeat (4) @(posedge clk_sys);
            mdl[TSD_REG_BOOT] = {8'h0, boot_in.tile_num, 7'h0, boot_in.boot_ovr, 2'h0,
                boot_in.second_core_off, boot_in.no_otp_poll, boot_in.boot_ram,
                boot_in.boot_jtag, boot_in.pll_mode};
            rdchk(TSD_REG_BOOT);
        end
        wr(TSD_REG_BOOT, 32'hffffffff);
        rdchk(TSD_REG_BOOT);
        rdchk(TSD_REG_RAMSZ);
        rdchk(8'h04);
        rdchk(8'h0b);
        chk("sec reset", 32'h0, sec_cfg);
        @(posedge clk_sys);
        otp_load <= 1'b1;
        otp_sec_word <= $urandom & 32'h7fffffff;
        @(posedge clk_sys);
        otp_load <= 1'b0;
        #1;
        mdl[TSD_REG_SEC] = otp_sec_word & TSD_SEC_MASK;
        chk("sec out", mdl[TSD_REG_SEC], sec_cfg);
        rdchk(TSD_REG_SEC);
        repeat (3) begin
            wr(TSD_REG_SEC, $urandom & 32'h7fffffff);
            rdchk(TSD_REG_SEC);
        end
        wr(TSD_REG_SEC, $urandom | 32'h80000000);
        wr(TSD_REG_SEC, $urandom);
        rdchk(TSD_REG_SEC);
        chk("sec out", mdl[TSD_REG_SEC], sec_cfg);
        chk("osc en", 32'h0, {30'h0, osc_core_en, osc_peri_en});
        for (int m = 0; m < 4; m++) begin
            wr(TSD_REG_RO_CTRL, 32'(m) | 32'hfffffff0);
            chk("osc en", 32'(m), {30'h0, osc_core_en, osc_peri_en});
            rdchk(TSD_REG_RO_CTRL);
        end
        repeat (30) @(posedge clk_sys);
        wr(TSD_REG_RO_CTRL, 32'h0);
        // Let the stopped counts settle before sampling
        repeat (TSD_RO_SETTLE_CYC) @(posedge clk_sys);
        for (int k = 0; k < 4; k++) begin
            rd(8'(TSD_REG_RO_TC + k), cnt[k]);
            chk("count upper", 32'h0, cnt[k] & 32'hffff0000);
            chk("count moved", 32'h1, {31'h0, (cnt[k] != 32'h0) === 1'b1});
        end
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        mdl[TSD_REG_SEC] = 32'h0;
        mdl[TSD_REG_RO_CTRL] = 32'h0;
        repeat (3) @(posedge clk_sys);
        for (int k = 0; k < 4; k++) begin
            rd(8'(TSD_REG_RO_TC + k), rv);
            chk("count kept", cnt[k], rv);
        end
        rdchk(TSD_REG_SEC);
        @(posedge clk_sys);
        debug_entry <= 1'b1;
        dbg_cap <= {$urandom, $urandom, $urandom};
        @(posedge clk_sys);
        debug_entry <= 1'b0;
        mdl[TSD_REG_DSTAT] = dbg_cap.saved_status_word & TSD_DSTAT_MASK;
        mdl[TSD_REG_DPC] = dbg_cap.saved_program_counter;
        mdl[TSD_REG_DSP] = dbg_cap.saved_stack_pointer;
        for (int r = 16; r < 19; r++) rdchk(8'(r));
        wr(TSD_REG_DPC, $urandom);
        wr(TSD_REG_DSTAT, $urandom);
        rdchk(TSD_REG_DPC);
        rdchk(TSD_REG_DSTAT);
        @(posedge clk_sys);
        debug_mode <= 1'b1;
        for (int r = 16; r < 21; r++) begin
            wr(8'(r), $urandom);
            rdchk(8'(r));
        end
        chk("fetch thread", mdl[TSD_REG_DTHR], {24'h0, fetch_thread});
        chk("fetch regnum", mdl[TSD_REG_DRNUM], {27'h0, fetch_regnum});
        @(posedge clk_sys);
        debug_mode <= 1'b0;
        wr(TSD_REG_DTHR, $urandom);
        chk("fetch thread", mdl[TSD_REG_DTHR], {24'h0, fetch_thread});
        end_sim();
    end

    // Run needs well under a thousand cycles
    initial begin
        #100000;
        err_total++;
        end_sim();
    end
endmodule

`default_nettype wire
